// [design/tap_regs.vh]
/*
  Constants for the boundary-scan test access port: instruction codes,
  register lengths, capture patterns and timing figures.
  Assumes inclusion by bare name from the port logic.
*/
`ifndef TAP_REGS_VH
`define TAP_REGS_VH

// Register lengths
`define IR_LEN        10
`define USER_FIXED_LEN 25
`define USER_SEL_LEN  7
`define ID_LEN        32
`define CFG_LEN       32

// Boundary register length per size variant, smallest first
`define BSR_LEN_V0    438
`define BSR_LEN_V1    690
`define BSR_LEN_V2    798
`define BSR_LEN_V3    1050

// Instruction codes
`define INS_EXTEST    10'h000
`define INS_SAMPLE    10'h055
`define INS_IDCODE    10'h006
`define INS_USERCODE  10'h007
`define INS_CFG_LOAD  10'h002
`define INS_BYPASS    10'h3ff

// Pattern loaded into the instruction shifter on capture
`define IR_CAPTURE    10'h001

// Data register selector codes
`define SEL_BYPASS    3'h0
`define SEL_ID        3'h1
`define SEL_USER      3'h2
`define SEL_BSR       3'h3
`define SEL_CFG       3'h4

// Link clock figures
`define TCK_MIN_PERIOD_NS 100
`define CLK_PERIOD_NS     10
`define TCK_MIN_CYCLES    ((`TCK_MIN_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Configuration word buffer
`define CFG_FIFO_DEPTH 16
`define CFG_FIFO_AW    4

`endif

// [design/word_fifo.v]
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module word_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      // Pointers wrap; depth is a power of two
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// [design/scan_port.v]
/*
  Boundary-scan test access port with bypass, identification, user
  signature, boundary and reconfiguration data registers.
  Assumes TCK, TMS, TDI and pin levels arrive asynchronously to clk,
  with TCK at most a tenth of the clk rate.
*/
// Functional notes
// - The instruction register is 10 bits and shifts between TDI and TDO in instruction scans.
// - The user signature is 32 bits, 7 chosen by the user and 25 fixed by the device.
// - Sample/preload captures the pins without disturbing them and stores a pattern for later.
// - Extest drives the boundary pattern onto outputs and captures the input pin levels.
// - Bypass puts a single bit between TDI and TDO while normal operation continues.
// - Usercode puts the user signature register between TDI and TDO for shifting out.
// - Idcode puts the identification register between TDI and TDO for shifting out.
// - The identification value is version, part number, maker identity and one bit, MSB first.
// - The identification value always ends in a least significant 1.
// - Boundary register length is 438, 690, 798 or 1050 cells by size variant.
// - Reconfiguration instructions carry configuration words in through the port.
`timescale 1ns/1ns
`include "tap_regs.vh"
module scan_port #(
  parameter VARIANT     = 0,
  parameter BSR_LEN     = (VARIANT == 0) ? `BSR_LEN_V0 :
                          (VARIANT == 1) ? `BSR_LEN_V1 :
                          (VARIANT == 2) ? `BSR_LEN_V2 : `BSR_LEN_V3,
  // Arbitrary identity values
  parameter [3:0]  ID_VERSION = 4'h0,
  parameter [15:0] ID_PART    = 16'h1234,
  parameter [10:0] ID_MAKER   = 11'h155,
  parameter [24:0] USER_FIXED = 25'h000_0000
) (
  input  wire               clk,
  input  wire               rst,
  input  wire               tck,
  input  wire               tms,
  input  wire               tdi,
  output reg                tdo,
  output reg                tdo_oe,
  input  wire [6:0]         user_sig,
  input  wire [BSR_LEN-1:0] pin_in,
  input  wire [BSR_LEN-1:0] core_out,
  output reg  [BSR_LEN-1:0] pin_out,
  output wire               extest_active,
  output wire               cfg_valid,
  input  wire               cfg_ready,
  output wire [31:0]        cfg_data,
  output reg                cfg_overrun
);
  localparam [3:0] ST_RESET   = 4'h0;
  localparam [3:0] ST_IDLE    = 4'h1;
  localparam [3:0] ST_SEL_DR  = 4'h2;
  localparam [3:0] ST_CAP_DR  = 4'h3;
  localparam [3:0] ST_SH_DR   = 4'h4;
  localparam [3:0] ST_EX1_DR  = 4'h5;
  localparam [3:0] ST_PAU_DR  = 4'h6;
  localparam [3:0] ST_EX2_DR  = 4'h7;
  localparam [3:0] ST_UPD_DR  = 4'h8;
  localparam [3:0] ST_SEL_IR  = 4'h9;
  localparam [3:0] ST_CAP_IR  = 4'ha;
  localparam [3:0] ST_SH_IR   = 4'hb;
  localparam [3:0] ST_EX1_IR  = 4'hc;
  localparam [3:0] ST_PAU_IR  = 4'hd;
  localparam [3:0] ST_EX2_IR  = 4'he;
  localparam [3:0] ST_UPD_IR  = 4'hf;

  // Two flops on every asynchronous input before use
  reg               tck_s1;
  reg               tck_s2;
  reg               tck_d;
  reg               tms_s1;
  reg               tms_s2;
  reg               tdi_s1;
  reg               tdi_s2;
  reg [BSR_LEN-1:0] pin_s1;
  reg [BSR_LEN-1:0] pin_s2;

  reg [3:0]             state;
  reg [`IR_LEN-1:0]     ir;
  reg [`IR_LEN-1:0]     ir_sh;
  reg                   bypass_sh;
  reg [`ID_LEN-1:0]     id_sh;
  reg [`ID_LEN-1:0]     user_sh;
  reg [`CFG_LEN-1:0]    cfg_sh;
  reg [BSR_LEN-1:0]     bsr_sh;
  reg [BSR_LEN-1:0]     bsr_upd;
  reg                   cfg_pend;
  reg [`CFG_LEN-1:0]    cfg_word;

  wire                  tck_rise;
  wire                  tck_fall;
  wire [2:0]            sel;
  wire                  cfg_push;
  wire                  fifo_ready;
  wire [`ID_LEN-1:0]    id_value;
  wire [`ID_LEN-1:0]    user_value;
  wire                  shifting;

  function [3:0] tap_next;
    input [3:0] st;
    input       m;
    begin
      case (st)
        ST_RESET:  tap_next = m ? ST_RESET  : ST_IDLE;
        ST_IDLE:   tap_next = m ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  tap_next = m ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: tap_next = m ? ST_RESET  : ST_CAP_IR;
        ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  tap_next = m ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
        default:   tap_next = m ? ST_SEL_DR : ST_IDLE;
      endcase
    end
  endfunction

  // Unknown codes fall back to bypass, as the standard expects
  function [2:0] dr_select;
    input [`IR_LEN-1:0] code;
    begin
      if (code == `INS_IDCODE) begin
        dr_select = `SEL_ID;
      end else if (code == `INS_USERCODE) begin
        dr_select = `SEL_USER;
      end else if (code == `INS_EXTEST || code == `INS_SAMPLE) begin
        dr_select = `SEL_BSR;
      end else if (code == `INS_CFG_LOAD) begin
        dr_select = `SEL_CFG;
      end else begin
        dr_select = `SEL_BYPASS;
      end
    end
  endfunction

  assign tck_rise      = tck_s2 & ~tck_d;
  assign tck_fall      = ~tck_s2 & tck_d;
  assign sel           = dr_select(ir);
  assign id_value      = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  assign user_value    = {USER_FIXED, user_sig};
  assign extest_active = (ir == `INS_EXTEST);
  assign shifting      = (state == ST_SH_DR) || (state == ST_SH_IR);
  assign cfg_push      = tck_rise && (state == ST_UPD_DR) && (sel == `SEL_CFG);

  always @(posedge clk) begin
    if (rst) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_d  <= 1'b0;
      tms_s1 <= 1'b1;
      tms_s2 <= 1'b1;
      tdi_s1 <= 1'b1;
      tdi_s2 <= 1'b1;
      pin_s1 <= {BSR_LEN{1'b0}};
      pin_s2 <= {BSR_LEN{1'b0}};
    end else begin
      tck_s1 <= tck;
      tck_s2 <= tck_s1;
      tck_d  <= tck_s2;
      tms_s1 <= tms;
      tms_s2 <= tms_s1;
      tdi_s1 <= tdi;
      tdi_s2 <= tdi_s1;
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // Controller and scan registers advance on the rising TCK edge
  always @(posedge clk) begin
    if (rst) begin
      state     <= ST_RESET;
      ir        <= `INS_IDCODE;
      ir_sh     <= {`IR_LEN{1'b0}};
      bypass_sh <= 1'b0;
      id_sh     <= {`ID_LEN{1'b0}};
      user_sh   <= {`ID_LEN{1'b0}};
      cfg_sh    <= {`CFG_LEN{1'b0}};
      bsr_sh    <= {BSR_LEN{1'b0}};
      bsr_upd   <= {BSR_LEN{1'b0}};
    end else if (tck_rise) begin
      state <= tap_next(state, tms_s2);
      case (state)
        ST_RESET: begin
          ir <= `INS_IDCODE;
        end
        ST_CAP_IR: begin
          ir_sh <= `IR_CAPTURE;
        end
        ST_SH_IR: begin
          ir_sh <= {tdi_s2, ir_sh[`IR_LEN-1:1]};
        end
        ST_UPD_IR: begin
          ir <= ir_sh;
        end
        ST_CAP_DR: begin
          bypass_sh <= 1'b0;
          id_sh     <= id_value;
          user_sh   <= user_value;
          bsr_sh    <= pin_s2;
          cfg_sh    <= {`CFG_LEN{1'b0}};
        end
        ST_SH_DR: begin
          if (sel == `SEL_ID) begin
            id_sh <= {tdi_s2, id_sh[`ID_LEN-1:1]};
          end else if (sel == `SEL_USER) begin
            user_sh <= {tdi_s2, user_sh[`ID_LEN-1:1]};
          end else if (sel == `SEL_BSR) begin
            bsr_sh <= {tdi_s2, bsr_sh[BSR_LEN-1:1]};
          end else if (sel == `SEL_CFG) begin
            cfg_sh <= {tdi_s2, cfg_sh[`CFG_LEN-1:1]};
          end else begin
            bypass_sh <= tdi_s2;
          end
        end
        ST_UPD_DR: begin
          if (sel == `SEL_BSR) begin
            bsr_upd <= bsr_sh;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // TDO changes on the falling edge so the far side samples it stable
  always @(posedge clk) begin
    if (rst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= shifting;
      if (state == ST_SH_IR) begin
        tdo <= ir_sh[0];
      end else if (sel == `SEL_ID) begin
        tdo <= id_sh[0];
      end else if (sel == `SEL_USER) begin
        tdo <= user_sh[0];
      end else if (sel == `SEL_BSR) begin
        tdo <= bsr_sh[0];
      end else if (sel == `SEL_CFG) begin
        tdo <= cfg_sh[0];
      end else begin
        tdo <= bypass_sh;
      end
    end
  end

  // Sample leaves the pins to the core; only extest drives the pattern
  always @(posedge clk) begin
    if (rst) begin
      pin_out <= {BSR_LEN{1'b0}};
    end else if (extest_active) begin
      pin_out <= bsr_upd;
    end else begin
      pin_out <= core_out;
    end
  end

  // One word waits here while the buffer is full; a second one is lost
  always @(posedge clk) begin
    if (rst) begin
      cfg_pend    <= 1'b0;
      cfg_word    <= {`CFG_LEN{1'b0}};
      cfg_overrun <= 1'b0;
    end else begin
      if (cfg_push) begin
        if (cfg_pend && !fifo_ready) begin
          cfg_overrun <= 1'b1;
        end else begin
          cfg_pend <= 1'b1;
          cfg_word <= cfg_sh;
        end
      end else if (cfg_pend && fifo_ready) begin
        cfg_pend <= 1'b0;
      end
    end
  end

  word_fifo #(
    .WIDTH (`CFG_LEN),
    .DEPTH (`CFG_FIFO_DEPTH),
    .AW    (`CFG_FIFO_AW)
  ) u_cfg_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (cfg_pend),
    .in_ready  (fifo_ready),
    .in_data   (cfg_word),
    .out_valid (cfg_valid),
    .out_ready (cfg_ready),
    .out_data  (cfg_data)
  );
endmodule

// [tb/scan_port_assertions.sv]
/* Pin-level assertions for scan_port.
   Assumes binding to scan_port with its BSR_LEN. */
`timescale 1ns/1ns
module scan_port_assertions #(parameter BSR_LEN = 438) (
  input wire               clk,
  input wire               rst,
  input wire               tck,
  input wire               tms,
  input wire               tdi,
  input wire               tdo,
  input wire               tdo_oe,
  input wire [6:0]         user_sig,
  input wire [BSR_LEN-1:0] pin_in,
  input wire [BSR_LEN-1:0] core_out,
  input wire [BSR_LEN-1:0] pin_out,
  input wire               extest_active,
  input wire               cfg_valid,
  input wire               cfg_ready,
  input wire [31:0]        cfg_data,
  input wire               cfg_overrun
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property ($fell(rst) |-> !tdo_oe && !cfg_valid && !cfg_overrun)
    else $error("outputs active after reset");
  a_pins_follow: assert property (!extest_active |=> pin_out == $past(core_out))
    else $error("pins disturbed outside extest");
  // tdo and tdo_oe move on falling link edges only, so low phase must be seen
  a_tdo_edge: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");
  a_oe_edge: assert property ($changed(tdo_oe) |-> !tck)
    else $error("tdo_oe moved while tck high");
  a_extest_edge: assert property ($changed(extest_active) |-> tck)
    else $error("instruction changed off a rising edge");
  a_cfg_hold: assert property (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data))
    else $error("config word lost while stalled");
  a_cfg_pop: assert property ($fell(cfg_valid) |-> $past(cfg_ready))
    else $error("config valid dropped without pop");
  a_overrun_sticky: assert property (cfg_overrun |=> cfg_overrun)
    else $error("overrun flag cleared");
  a_overrun_full: assert property ($rose(cfg_overrun) |-> $past(cfg_valid))
    else $error("overrun with empty buffer");
  c_pop: cover property (cfg_valid && cfg_ready);
  c_extest: cover property ($rose(extest_active));
  c_shift: cover property ($rose(tdo_oe));
endmodule

bind scan_port scan_port_assertions #(.BSR_LEN(BSR_LEN)) chk (.clk(clk), .rst(rst),
  .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .user_sig(user_sig),
  .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out), .extest_active(extest_active),
  .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_data(cfg_data),
  .cfg_overrun(cfg_overrun));

// [tb/scan_host.sv]
/* Link controller model: drives tck, tms, tdi; reads tdo.
   Assumes tdo arrives resolved with the pin pull-up. */
`timescale 1ns/1ns
module scan_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input  wire  tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One 125 ns link cycle; tck stands low between cycles
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #60 o = tdo;
    tck = 1'b1;
    #65 tck = 1'b0;
  endtask
  task automatic park();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  // Never enters the pause states, so tests stay out of them
  task automatic scan(input logic ir, input int n, input logic [1049:0] din,
                      output logic [1049:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, ~din[n-1], o);
  endtask
endmodule

// [tb/scan_port_tb.sv]
/* Self-checking bench for scan_port.
   Assumes 100 MHz clk, size variant 0 and arbitrary identity values. */
`timescale 1ns/1ns
module scan_port_tb;
  localparam int BL = 438;
  localparam logic [3:0]  VER   = 4'h3;
  localparam logic [15:0] PART  = 16'h5a3c;
  localparam logic [10:0] MAKER = 11'h2b1;
  localparam logic [24:0] UFIX  = 25'h0a5_5a5a;
  logic clk = 1'b0, rst = 1'b1, cfg_ready = 1'b0;
  logic [6:0] user_sig = '0;
  logic [BL-1:0] pin_in = '0, core_out = '0;
  wire tck, tms, tdi, tdo, tdo_oe, extest_active, cfg_valid, cfg_overrun, tdo_w;
  wire [BL-1:0] pin_out;
  wire [31:0] cfg_data;
  logic [31:0] cfg_q[$];
  logic [1049:0] din, dout, exp_v;
  int error_cnt = 0, check_count = 0;
  always #5 clk = ~clk;
  assign tdo_w = tdo_oe ? tdo : 1'b1; // Weak pull-up when released
  scan_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));
  scan_port #(.VARIANT(0), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER),
    .USER_FIXED(UFIX)) dut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .user_sig(user_sig), .pin_in(pin_in),
    .core_out(core_out), .pin_out(pin_out), .extest_active(extest_active),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_data(cfg_data),
    .cfg_overrun(cfg_overrun));
  function automatic logic [1049:0] rnd();
    for (int i = 0; i < 1050; i += 30) rnd[i+:30] = $urandom;
  endfunction
  task automatic chk_scan(input logic [1049:0] got, exp, input int n);
    logic [1049:0] m;
    m = {1050{1'b1}} >> (1050 - n);
    check_count++;
    if ((got & m) !== (exp & m)) begin
      error_cnt++;
      $display("unexpected at %0t: scan of %0d bits got %h", $time, n, got & m);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Oldest noted config word against each word popped
  always @(posedge clk)
    if (!rst && cfg_valid === 1'b1 && cfg_ready === 1'b1)
      chk_word(cfg_data, cfg_q.size() ? cfg_q.pop_front() : ~cfg_data);
  initial begin
    #800000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hb9f0));
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    din = rnd();
    core_out = din[BL-1:0];
    host.park();
    host.scan(1'b0, 32, '0, dout);
    chk_scan(dout, {VER, PART, MAKER, 1'b1}, 32);
    host.scan(1'b1, 10, 10'h007, dout);
    chk_scan(dout, 10'h001, 10);
    chk_word(tdo_oe, 1'b0);
    @(negedge clk);
    user_sig = $urandom;
    host.scan(1'b0, 32, '0, dout);
    chk_scan(dout, {UFIX, user_sig}, 32);
    host.park();
    host.scan(1'b0, 32, '0, dout);
    chk_scan(dout, {VER, PART, MAKER, 1'b1}, 32);
    for (int k = 0; k < 2; k++) begin
      host.scan(1'b1, 10, k ? 10'h2aa : 10'h3ff, dout);
      din = rnd();
      host.scan(1'b0, 9, din, dout);
      chk_scan(dout, {din[7:0], 1'b0}, 9);
    end
    host.scan(1'b1, 10, 10'h055, dout);
    exp_v = rnd();
    @(negedge clk);
    pin_in = exp_v[BL-1:0];
    din = rnd();
    exp_v[BL] = din[0];
    host.scan(1'b0, BL + 1, din, dout);
    chk_scan(dout, exp_v, BL + 1);
    chk_word(pin_out === core_out, 1'b1);
    host.scan(1'b1, 10, 10'h000, dout);
    chk_word(extest_active, 1'b1);
    exp_v = din >> 1;
    chk_word(pin_out === exp_v[BL-1:0], 1'b1);
    exp_v = rnd();
    @(negedge clk);
    pin_in = exp_v[BL-1:0];
    host.scan(1'b0, BL, '0, dout);
    chk_scan(dout, exp_v, BL);
    host.scan(1'b1, 10, 10'h002, dout);
    for (int i = 0; i < 18; i++) begin
      din = rnd();
      if (i < 17) cfg_q.push_back(din[31:0]);
      host.scan(1'b0, 32, din, dout);
      chk_word(cfg_overrun, i == 17);
    end
    @(negedge clk);
    cfg_ready = 1'b1;
    for (int k = 0; k < 200 && cfg_q.size() > 0; k++) @(negedge clk);
    repeat (4) @(negedge clk);
    chk_word(cfg_q.size(), 0);
    chk_word(cfg_valid, 1'b0);
    tally_and_finish();
  end
endmodule
